// ---- rtl/ffep_pkg.sv ----
// package of constants and types for the four-phase fetch/execute pipeline
package ffep_pkg;
	// ****************************************
	// widths and reset values
	// ****************************************
	localparam int unsigned PC_W = 12;
	localparam int unsigned IW_W = 15;
	localparam int unsigned DW = 8;
	localparam int unsigned DA_W = 8;
	localparam logic [11:0] RESET_VECTOR = 12'h000;
	localparam logic [14:0] NOP_WORD = 15'h0000;
	localparam logic [11:0] PC_ONE = 12'h001;
	// mapped control register addresses in data memory
	localparam logic [7:0] ADDR_ACC = 8'h05;
	localparam logic [7:0] ADDR_PC_LOW_BYTE = 8'h06;
	// ****************************************
	// instruction encoding: [14:12] class, [11:0] operand
	// ****************************************
	localparam int unsigned OP_HI = 14;
	localparam int unsigned OP_LO = 12;
	localparam logic [2:0] OP_NOP = 3'h0;
	localparam logic [2:0] OP_JMP = 3'h1;
	localparam logic [2:0] OP_CALL = 3'h2;
	localparam logic [2:0] OP_ALU = 3'h3;
	localparam logic [2:0] OP_MOVAM = 3'h4;
	localparam logic [2:0] OP_SZA = 3'h5;
	localparam logic [2:0] OP_MOVIA = 3'h6;
	localparam logic [2:0] OP_MOVMA = 3'h7;
	// alu function in bits [11:8] of an alu word, memory address in [7:0]
	localparam int unsigned FN_HI = 11;
	localparam int unsigned FN_LO = 8;
	localparam logic [3:0] FN_ADD = 4'h0;
	localparam logic [3:0] FN_SUB = 4'h1;
	localparam logic [3:0] FN_AND = 4'h2;
	localparam logic [3:0] FN_OR = 4'h3;
	localparam logic [3:0] FN_XOR = 4'h4;
	localparam logic [3:0] FN_RL = 4'h5;
	localparam logic [3:0] FN_RR = 4'h6;
	localparam logic [3:0] FN_INC = 4'h7;
	localparam logic [3:0] FN_DEC = 4'h8;
	localparam logic [3:0] FN_CPL = 4'h9;
	// ****************************************
	// phase sequencer states
	// ****************************************
	typedef enum logic [1:0] {PH_T1, PH_T2, PH_T3, PH_T4} ffep_phase_type;
endpackage : ffep_pkg

// ---- rtl/ffep_alu_if.sv ----
// interface carrying operands and result between core and arithmetic unit
interface ffep_alu_if;
	logic [7:0] opa; // accumulator operand
	logic [7:0] opb; // memory operand
	logic [3:0] fn; // function select
	logic [7:0] res; // result
	logic zero; // result is zero
	modport core (output opa, output opb, output fn, input res, input zero);
	modport alu (input opa, input opb, input fn, output res, output zero);
endinterface : ffep_alu_if

// ---- rtl/ffep_alu.sv ----
// 8-bit arithmetic unit of the pipeline
module ffep_alu (
	ffep_alu_if.alu bus
);
	// ****************************************
	// function decode
	// ****************************************
	// one selection chain keeps every function on a single 8-bit path
	wire [7:0] r_add = bus.opa + bus.opb;
	wire [7:0] r_sub = bus.opa - bus.opb;
	wire [7:0] r_rl = {bus.opa[6:0], bus.opa[7]};
	wire [7:0] r_rr = {bus.opa[0], bus.opa[7:1]};
	wire [7:0] r_inc = bus.opb + 8'h01;
	wire [7:0] r_dec = bus.opb - 8'h01;
	assign bus.res = (bus.fn == ffep_pkg::FN_ADD) ? r_add :
		(bus.fn == ffep_pkg::FN_SUB) ? r_sub :
		(bus.fn == ffep_pkg::FN_AND) ? (bus.opa & bus.opb) :
		(bus.fn == ffep_pkg::FN_OR) ? (bus.opa | bus.opb) :
		(bus.fn == ffep_pkg::FN_XOR) ? (bus.opa ^ bus.opb) :
		(bus.fn == ffep_pkg::FN_RL) ? r_rl :
		(bus.fn == ffep_pkg::FN_RR) ? r_rr :
		(bus.fn == ffep_pkg::FN_INC) ? r_inc :
		(bus.fn == ffep_pkg::FN_DEC) ? r_dec :
		(bus.fn == ffep_pkg::FN_CPL) ? ~bus.opb :
		bus.opb; // pass through for moves
	// skip decision uses the zero flag
	assign bus.zero = (bus.res == 8'h00);
endmodule : ffep_alu

// ---- rtl/ffep_core.sv ----
// top of the four-phase fetch/execute pipeline with tiny data memory
module ffep_core (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	// program memory read port
	output logic [11:0] o_pm_addr,
	input wire logic [14:0] i_pm_data,
	// phase clocks and status
	output logic [3:0] o_phase_clocks,
	output logic [11:0] o_pc,
	output logic [7:0] o_acc,
	output logic o_retire,
	output logic o_idle_cycle
);
	// ****************************************
	// reset release
	// ****************************************
	// release is taken through two flops so every register leaves reset on one edge,
	// while assertion still clears the core at once without waiting for a clock
	logic rst_s1; // first stage, read only by rst_s2
	logic rst_s2; // released reset, active low while in reset
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rst_s1 <= 1'b0;
			rst_s2 <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_s2 <= rst_s1;
		end
	end
	// every other register in the core except the dmem array resets from this released copy
	wire rstn = rst_s2;

	// ****************************************
	// phase sequencer
	// ****************************************
	ffep_pkg::ffep_phase_type phase; // current phase
	ffep_pkg::ffep_phase_type next_phase;
	always_comb begin
		case (phase)
			ffep_pkg::PH_T1: next_phase = ffep_pkg::PH_T2;
			ffep_pkg::PH_T2: next_phase = ffep_pkg::PH_T3;
			ffep_pkg::PH_T3: next_phase = ffep_pkg::PH_T4;
			ffep_pkg::PH_T4: next_phase = ffep_pkg::PH_T1;
			default: next_phase = ffep_pkg::PH_T1;
		endcase
	end
	// sequencer restarts at phase one
	always_ff @(posedge i_sys_clk or negedge rstn) begin
		if (!rstn) phase <= ffep_pkg::PH_T1;
		else phase <= next_phase;
	end
	wire is_t1 = (phase == ffep_pkg::PH_T1);
	wire is_t4 = (phase == ffep_pkg::PH_T4);
	// built from next_phase so the one-hot copy lines up with phase, and being a
	// register it cannot glitch two phases high in the same cycle
	// one-hot phases from a register, so never two at once
	logic [3:0] phase_clocks;
	always_ff @(posedge i_sys_clk or negedge rstn) begin
		if (!rstn) phase_clocks <= 4'h1;
		else phase_clocks <= 4'h1 << next_phase;
	end
	assign o_phase_clocks = phase_clocks;

	// ****************************************
	// pipeline registers
	// ****************************************
	logic [11:0] pc; // address of next fetch
	logic [14:0] ir; // instruction under execution
	logic [14:0] fetch_buf; // word fetched this cycle
	logic ir_valid; // ir holds a real instruction
	logic fb_valid; // fetch_buf holds a usable word
	logic [7:0] acc; // accumulator
	// data memory has no reset: a word never stored reads back unknown,
	// so programs must store before they load
	logic [7:0] dmem [0:255]; // data memory, low addresses mirror control regs
	logic retire;
	logic idle_cycle;

	// ****************************************
	// decode, continuous during phases two to four
	// ****************************************
	wire [2:0] op = ir[ffep_pkg::OP_HI:ffep_pkg::OP_LO];
	wire [7:0] maddr = ir[7:0];
	wire is_branch = ir_valid && (op == ffep_pkg::OP_JMP || op == ffep_pkg::OP_CALL);
	wire pc_low_wr = ir_valid && (op == ffep_pkg::OP_MOVAM) &&
		(maddr == ffep_pkg::ADDR_PC_LOW_BYTE);
	// reads of mapped registers return live state
	wire [7:0] mem_rd = (maddr == ffep_pkg::ADDR_PC_LOW_BYTE) ? pc[7:0] :
		(maddr == ffep_pkg::ADDR_ACC) ? acc : dmem[maddr];

	ffep_alu_if alu_bus ();
	// memory operands reach the accumulator only through the arithmetic unit
	assign alu_bus.opa = acc;
	assign alu_bus.opb = (op == ffep_pkg::OP_MOVIA) ? ir[7:0] : mem_rd;
	// moves and skips use the unit's pass-through code, so every value that
	// reaches the accumulator still crosses the arithmetic unit
	assign alu_bus.fn = (op == ffep_pkg::OP_ALU) ? ir[ffep_pkg::FN_HI:ffep_pkg::FN_LO] : 4'hf;
	ffep_alu u_alu (
		.bus(alu_bus.alu)
	);
	// skip decision comes from the unit's zero flag on the memory operand
	wire skip_taken = ir_valid && (op == ffep_pkg::OP_SZA) && alu_bus.zero;
	// any flow change spoils the prefetched word
	wire flush = is_branch || skip_taken || pc_low_wr;
	// during execute pc already points one past the prefetched word, so a taken
	// skip keeps pc as it is: the discarded word is the one skipped over
	wire [11:0] branch_pc = is_branch ? ir[11:0] :
		pc_low_wr ? {pc[11:8], acc} : pc; // page jump keeps high bits

	// ****************************************
	// fetch in phase one
	// ****************************************
	// pc steps at the end of phase one, word latched that phase
	always_ff @(posedge i_sys_clk or negedge rstn) begin
		if (!rstn) begin
			pc <= ffep_pkg::RESET_VECTOR;
			fetch_buf <= ffep_pkg::NOP_WORD;
			fb_valid <= 1'b0;
		end else if (is_t1) begin
			pc <= pc + ffep_pkg::PC_ONE;
			fetch_buf <= i_pm_data;
			fb_valid <= 1'b1;
		end else if (is_t4 && flush) begin
			// flow change: load the new pc, drop the word fetched in phase one
			pc <= branch_pc; // target loaded, idle cycle follows
			fb_valid <= 1'b0; // prefetch discarded
		end
	end
	// fetch address comes straight from the pc register, so it is glitch-free
	assign o_pm_addr = pc;

	// ****************************************
	// execute at end of phase four
	// ****************************************
	// next ir comes from this cycle's fetch, overlapping execute
	always_ff @(posedge i_sys_clk or negedge rstn) begin
		if (!rstn) begin
			ir <= ffep_pkg::NOP_WORD;
			ir_valid <= 1'b0; // pipeline emptied
			acc <= 8'h00;
			retire <= 1'b0;
			idle_cycle <= 1'b0;
		end else if (is_t4) begin
			// results written only after decode in t2..t3
			// acc only loads for words that produce a result
			if (ir_valid && (op == ffep_pkg::OP_ALU || op == ffep_pkg::OP_MOVMA ||
				op == ffep_pkg::OP_MOVIA)) acc <= alu_bus.res;
			ir <= fetch_buf;
			ir_valid <= fb_valid && !flush;
			// one pulse per cycle: retire for a real word, idle for a bubble
			retire <= ir_valid;
			idle_cycle <= !ir_valid;
		end else begin
			retire <= 1'b0;
			idle_cycle <= 1'b0;
		end
	end
	// no reset on the array on purpose, so it can map onto a plain ram
	// stores to memory go from the accumulator
	always_ff @(posedge i_sys_clk) begin
		if (rstn && is_t4 && ir_valid && op == ffep_pkg::OP_MOVAM) dmem[maddr] <= acc;
	end
	assign o_pc = pc;
	assign o_acc = acc;
	assign o_retire = retire;
	assign o_idle_cycle = idle_cycle;

	// ****************************************
	// assertions
	// ****************************************
	// sequencer
	phase_onehot_a: assert property (@(posedge i_sys_clk) disable iff (!rstn)
		$onehot(phase_clocks)) else $error("phase clocks not one-hot");
	phase_map_a: assert property (@(posedge i_sys_clk) disable iff (!rstn)
		phase_clocks == (4'h1 << phase)) else $error("phase clocks off phase");
	phase_order_a: assert property (@(posedge i_sys_clk) disable iff (!rstn)
		is_t1 |=> phase == ffep_pkg::PH_T2 ##1 phase == ffep_pkg::PH_T3
		##1 phase == ffep_pkg::PH_T4 ##1 is_t1) else $error("phase order broken");
	pulse_once_a: assert property (@(posedge i_sys_clk) disable iff (!rstn)
		retire || idle_cycle |-> is_t1 && !(retire && idle_cycle))
		else $error("cycle pulse misplaced");
	// fetch and pc
	pc_step_a: assert property (@(posedge i_sys_clk) disable iff (!rstn)
		is_t1 |=> pc == $past(pc) + ffep_pkg::PC_ONE) else $error("pc did not step");
	fetch_hold_a: assert property (@(posedge i_sys_clk) disable iff (!rstn)
		!is_t1 |=> $stable(fetch_buf)) else $error("fetch outside phase one");
	pc_hold_a: assert property (@(posedge i_sys_clk) disable iff (!rstn)
		(phase == ffep_pkg::PH_T2) |=> $stable(pc) ##1 $stable(pc))
		else $error("pc moved in decode");
	acc_hold_a: assert property (@(posedge i_sys_clk) disable iff (!rstn)
		!is_t4 |=> $stable(acc)) else $error("acc moved before execute");
	overlap_a: assert property (@(posedge i_sys_clk) disable iff (!rstn)
		is_t4 && fb_valid && !flush |=> ir_valid && ir == $past(fetch_buf))
		else $error("no overlap");
	// flow changes
	branch_idle_a: assert property (@(posedge i_sys_clk) disable iff (!rstn)
		is_t4 && is_branch |=> !ir_valid) else $error("branch kept prefetch");
	branch_tgt_a: assert property (@(posedge i_sys_clk) disable iff (!rstn)
		is_t4 && is_branch |=> pc == $past(ir[11:0])) else $error("bad target");
	skip_flush_a: assert property (@(posedge i_sys_clk) disable iff (!rstn)
		is_t4 && skip_taken |=> !ir_valid ##4 idle_cycle) else $error("skip no idle");
	skip_pc_a: assert property (@(posedge i_sys_clk) disable iff (!rstn)
		is_t4 && skip_taken |=> pc == $past(pc)) else $error("skip lands wrong");
	pc_low_page_a: assert property (@(posedge i_sys_clk) disable iff (!rstn)
		is_t4 && pc_low_wr |=> pc == {$past(pc[11:8]), $past(acc)} && !ir_valid)
		else $error("pc low byte write wrong");
	// execute
	acc_alu_a: assert property (@(posedge i_sys_clk) disable iff (!rstn)
		is_t4 && ir_valid && op == ffep_pkg::OP_ALU |=> acc == $past(alu_bus.res))
		else $error("acc not from alu");
	store_mem_a: assert property (@(posedge i_sys_clk) disable iff (!rstn)
		is_t4 && ir_valid && op == ffep_pkg::OP_MOVAM |=> dmem[$past(maddr)] == $past(acc))
		else $error("store missed memory");

	// ****************************************
	// covers of the main scenarios
	// ****************************************
	retire_c: cover property (@(posedge i_sys_clk) disable iff (!rstn) retire ##4 retire);
	branch_c: cover property (@(posedge i_sys_clk) disable iff (!rstn) is_t4 && is_branch);
	skip_c: cover property (@(posedge i_sys_clk) disable iff (!rstn) is_t4 && skip_taken);
	pc_low_c: cover property (@(posedge i_sys_clk) disable iff (!rstn) is_t4 && pc_low_wr);
	idle_c: cover property (@(posedge i_sys_clk) disable iff (!rstn) idle_cycle ##4 retire);
endmodule : ffep_core

// ---- bench/tb.sv ----
// self-checking bench for the four-phase fetch/execute pipeline
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************
	// clock, reset, program image and design
	// ****************************************
	logic i_sys_clk = 1'b0; // 20 MHz system clock
	logic i_rstn = 1'b0; // active-low reset, held from time zero
	logic [14:0] rom [0:4095]; // program memory image
	logic [11:0] o_pm_addr;
	logic [14:0] i_pm_data;
	logic [3:0] o_phase_clocks;
	logic [11:0] o_pc;
	logic [7:0] o_acc;
	logic o_retire;
	logic o_idle_cycle;
	int fails = 0;
	int comparisons = 0;
	// half period of 25 ns gives 50 ns cycles
	always #25 i_sys_clk = ~i_sys_clk;
	// memory answers combinationally to the fetch address
	assign i_pm_data = rom[o_pm_addr];
	ffep_core u_dut (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .o_pm_addr(o_pm_addr),
		.i_pm_data(i_pm_data), .o_phase_clocks(o_phase_clocks), .o_pc(o_pc), .o_acc(o_acc),
		.o_retire(o_retire), .o_idle_cycle(o_idle_cycle));
	// ****************************************
	// shared helpers
	// ****************************************
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	function automatic logic [14:0] w(input logic [2:0] op, input logic [11:0] arg);
		return {op, arg};
	endfunction : w
	// reset for 5 cycles with a nop-filled image; caller loads code, then releases
	task automatic restart();
		@(posedge i_sys_clk);
		#1 i_rstn = 1'b0;
		foreach (rom[i]) rom[i] = ffep_pkg::NOP_WORD;
		repeat (5) @(posedge i_sys_clk);
		#1 chk(o_phase_clocks, 4'h1);
		chk(o_pc, 12'h000);
	endtask : restart
	// wait, bounded, for the next end-of-cycle pulse: bit 8 set means idle
	task automatic ev(input logic [8:0] e);
		int n;
		n = 0;
		do begin
			@(posedge i_sys_clk);
			#1 n++;
		end while (o_retire !== 1'b1 && o_idle_cycle !== 1'b1 && n < 12);
		chk({o_retire, o_idle_cycle}, {~e[8], e[8]});
		if (!e[8]) chk(o_acc, e[7:0]);
	endtask : ev
	task automatic play(input logic [8:0] q[$]);
		foreach (q[i]) ev(q[i]);
	endtask : play
	// ****************************************
	// scenarios
	// ****************************************
	// phases rotate one-hot, one bit a clock, T1 to T4
	task automatic phases();
		logic [3:0] seq [4] = '{4'h2, 4'h4, 4'h8, 4'h1};
		int n;
		restart();
		i_rstn = 1'b1;
		n = 0;
		while (o_phase_clocks === 4'h1 && n < 8) begin
			@(posedge i_sys_clk);
			#1 n++;
		end
		for (int i = 0; i < 8; i++) begin
			chk(o_phase_clocks, seq[i % 4]);
			chk(o_pm_addr, 16'(i / 4 + 1));
			@(posedge i_sys_clk);
			#1;
		end
	endtask : phases
	// every alu function back to back; pc steps by one per retired word
	task automatic straight();
		logic [7:0] exp [10] = '{8'he1, 8'h69, 8'h24, 8'hbd, 8'h99, 8'h4b, 8'hd2,
			8'h3d, 8'h3b, 8'hc3};
		logic [11:0] pc;
		restart();
		rom[0] = w(ffep_pkg::OP_MOVIA, 12'h03c);
		rom[1] = w(ffep_pkg::OP_MOVAM, 12'h010);
		for (int i = 0; i < 10; i++) begin
			rom[2 + 2 * i] = w(ffep_pkg::OP_MOVIA, 12'h0a5);
			rom[3 + 2 * i] = w(ffep_pkg::OP_ALU, {i[3:0], 8'h10});
		end
		rom[22] = w(ffep_pkg::OP_MOVMA, {4'h0, ffep_pkg::ADDR_ACC});
		i_rstn = 1'b1;
		play('{9'h100, 9'h03c, 9'h03c});
		pc = o_pc;
		for (int i = 0; i < 10; i++) begin
			ev(9'h0a5);
			chk(o_pc, pc + 12'h001);
			ev({1'b0, exp[i]});
			chk(o_pc, pc + 12'h002);
			pc = o_pc;
		end
		ev({1'b0, exp[9]});
	endtask : straight
	// jump and call each leave one idle cycle before the target runs
	task automatic branches();
		restart();
		rom[0] = w(ffep_pkg::OP_MOVIA, 12'h011);
		rom[1] = w(ffep_pkg::OP_JMP, 12'h020);
		rom[2] = w(ffep_pkg::OP_MOVIA, 12'h0ee);
		rom[32] = w(ffep_pkg::OP_MOVIA, 12'h022);
		rom[33] = w(ffep_pkg::OP_CALL, 12'h030);
		rom[34] = w(ffep_pkg::OP_MOVIA, 12'h0ee);
		rom[48] = w(ffep_pkg::OP_MOVIA, 12'h033);
		i_rstn = 1'b1;
		play('{9'h100, 9'h011, 9'h011, 9'h100, 9'h022, 9'h022, 9'h100, 9'h033});
	endtask : branches
	// taken and untaken skip, then a pc low byte store that jumps in page
	task automatic skips();
		restart();
		rom[0] = w(ffep_pkg::OP_MOVIA, 12'h000);
		rom[1] = w(ffep_pkg::OP_MOVAM, 12'h010);
		rom[2] = w(ffep_pkg::OP_SZA, 12'h010);
		rom[3] = w(ffep_pkg::OP_MOVIA, 12'h0ee);
		rom[4] = w(ffep_pkg::OP_MOVIA, 12'h044);
		rom[5] = w(ffep_pkg::OP_MOVAM, 12'h011);
		rom[6] = w(ffep_pkg::OP_SZA, 12'h011);
		rom[7] = w(ffep_pkg::OP_MOVIA, 12'h077);
		rom[8] = w(ffep_pkg::OP_MOVIA, 12'h040);
		rom[9] = w(ffep_pkg::OP_MOVAM, {4'h0, ffep_pkg::ADDR_PC_LOW_BYTE});
		rom[10] = w(ffep_pkg::OP_MOVIA, 12'h0ee);
		rom[64] = w(ffep_pkg::OP_MOVIA, 12'h099);
		rom[65] = w(ffep_pkg::OP_MOVMA, {4'h0, ffep_pkg::ADDR_PC_LOW_BYTE});
		i_rstn = 1'b1;
		play('{9'h100, 9'h000, 9'h000, 9'h000, 9'h100, 9'h044});
		play('{9'h044, 9'h044, 9'h077});
		play('{9'h040, 9'h040, 9'h100, 9'h099});
		ev(9'h043);
	endtask : skips
	// ****************************************
	// run control
	// ****************************************
	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_of_test
	initial begin
		foreach (rom[i]) rom[i] = ffep_pkg::NOP_WORD;
		phases();
		straight();
		branches();
		skips();
		end_of_test();
	end
	// watchdog: the run needs well under 1000 cycles
	initial begin
		#(3000 * 50);
		fails++;
		end_of_test();
	end
endmodule : tb
